// >>> rtl/fpb_pkg.sv
package fpb_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_STATE     = 8'h04;
  localparam logic [7:0] ADR_PROT_SEL  = 8'h08;
  localparam logic [7:0] ADR_PROT_DATA = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR   = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN    = 8'h18;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_EN_BIT    = 0;
  localparam int ST_BUSY_BIT    = 2;
  localparam int ST_MOD_BIT     = 3;
  localparam int ST_VALID_BIT   = 4;
  localparam int ST_GUARD_BIT   = 5;
  localparam int ST_PAGE_LSB    = 8;
  localparam logic CTRL_EN_RST  = 1'b1;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // Interrupt event bits.
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_SINGLE = 1;
  localparam int IRQ_DOUBLE = 2;
  localparam int IRQ_CONFL  = 3;

  // ==========================================================
  // Outcome codes
  localparam logic [1:0] STAT_OK       = 2'h0;
  localparam logic [1:0] STAT_CORR     = 2'h1;
  localparam logic [1:0] STAT_UNCORR   = 2'h2;
  localparam logic [1:0] STAT_CONFLICT = 2'h3;

  // ==========================================================
  // Command sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_DECIDE = 4'h2,
    ST_COPY   = 4'h4,
    ST_FINISH = 4'h8
  } fpb_state_t;

endpackage

// >>> rtl/fpb_page_ops.sv
`timescale 1ns/1ps
module fpb_page_ops
  import fpb_pkg::*;
#(
  parameter int PAGE_W = 8
)
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Fabric command port
  input  wire logic              unprotect_request,
  input  wire logic              discard_request,
  input  wire logic [PAGE_W-1:0] page_addr,
  input  wire logic              buffer_keep_guard,
  input  wire logic              buf_write,
  output logic                   busy,
  output logic [1:0]             status,
  output logic                   cmd_done,
  // Flash array copy port
  output logic                   arr_copy_req,
  output logic [PAGE_W-1:0]      arr_copy_page,
  input  wire logic              arr_copy_done,
  input  wire logic              arr_ecc_single,
  input  wire logic              arr_ecc_double,
  // Interrupt
  output logic                   irq
);

  localparam int PAGES = 1 << PAGE_W;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // ==========================================================
  // Declarations
  fpb_state_t        state_reg;
  logic [PAGE_W-1:0] cmd_page_reg;
  logic [PAGE_W-1:0] buf_page_reg;
  logic              buf_valid_reg;
  logic              modified_reg;
  logic [1:0]        status_reg;
  logic              done_reg;
  logic              copy_req_reg;
  logic              ctrl_en_reg;
  logic [PAGE_W-1:0] prot_sel_reg;
  logic              prot_mem [PAGES];
  logic [3:0]        irq_stat_reg;
  logic [3:0]        irq_en_reg;
  logic [3:0]        irq_ev;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic              wr_take;
  logic              rd_take;
  logic              start_unprot;
  logic              start_discard;
  logic              page_hit;
  logic              conflict;
  logic              copy_blocked;

  assign start_unprot  = ce && state_reg == ST_IDLE && ctrl_en_reg && unprotect_request;
  assign start_discard = ce && state_reg == ST_IDLE && ctrl_en_reg && discard_request
                         && !unprotect_request;
  assign page_hit      = buf_valid_reg && buf_page_reg == cmd_page_reg;
  // The guard blocks the copy only when the buffer is valid; only a modified one is a conflict.
  assign copy_blocked  = buf_valid_reg && buffer_keep_guard;
  assign conflict      = copy_blocked && modified_reg;

  // ==========================================================
  // Bus slave: one wait cycle, then the answer
  // The answer is held back while ce is low, so a frozen write is never lost.
  assign avs_waitrequest = (avs_read || avs_write) && !(ack_reg && ce);
  assign wr_take         = ce && avs_write && ack_reg && avs_byteenable[0];
  assign rd_take         = ce && avs_read && !ack_reg;
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      ack_reg <= 1'b0;
    else if (ce)
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata_reg <= 32'h0000_0000;
    else if (rd_take)
    begin
      rdata_reg <= 32'h0000_0000;
      if (hit(avs_address, ADR_CTRL))
        rdata_reg[CTRL_EN_BIT] <= ctrl_en_reg;
      else if (hit(avs_address, ADR_STATE))
      begin
        rdata_reg[1:0]          <= status_reg;
        rdata_reg[ST_BUSY_BIT]  <= busy;
        rdata_reg[ST_MOD_BIT]   <= modified_reg;
        rdata_reg[ST_VALID_BIT] <= buf_valid_reg;
        rdata_reg[ST_GUARD_BIT] <= buffer_keep_guard;
        rdata_reg[ST_PAGE_LSB +: PAGE_W] <= buf_page_reg;
      end
      else if (hit(avs_address, ADR_PROT_SEL))
        rdata_reg[PAGE_W-1:0] <= prot_sel_reg;
      else if (hit(avs_address, ADR_PROT_DATA))
        rdata_reg[0] <= prot_mem[prot_sel_reg];
      else if (hit(avs_address, ADR_IRQ_STAT))
        rdata_reg[3:0] <= irq_stat_reg;
      else if (hit(avs_address, ADR_IRQ_EN))
        rdata_reg[3:0] <= irq_en_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_en_reg  <= CTRL_EN_RST;
      prot_sel_reg <= '0;
      irq_en_reg   <= IRQ_EN_RST;
    end
    else if (wr_take)
    begin
      if (hit(avs_address, ADR_CTRL))
        ctrl_en_reg <= avs_writedata[CTRL_EN_BIT];
      if (hit(avs_address, ADR_PROT_SEL))
        prot_sel_reg <= avs_writedata[PAGE_W-1:0];
      if (hit(avs_address, ADR_IRQ_EN))
        irq_en_reg <= avs_writedata[3:0];
    end
  end

  // ==========================================================
  // Page protection bits
  // The command's clear takes priority over a software write in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < PAGES; i++)
        prot_mem[i] <= 1'b0;
    end
    else if (start_unprot)
      prot_mem[page_addr] <= 1'b0;
    else if (wr_take && hit(avs_address, ADR_PROT_DATA))
      prot_mem[prot_sel_reg] <= avs_writedata[0];
  end

  // ==========================================================
  // Command sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_reg <= ST_IDLE;
    else if (ce)
    begin
      case (state_reg)
        ST_IDLE:
          if (start_unprot)
            state_reg <= ST_DECIDE;
          else if (start_discard)
            state_reg <= ST_FINISH;
        ST_DECIDE:
          if (page_hit || copy_blocked)
            state_reg <= ST_FINISH;
          else
            state_reg <= ST_COPY;
        ST_COPY:
          if (arr_copy_done)
            state_reg <= ST_FINISH;
        ST_FINISH:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cmd_page_reg <= '0;
    else if (start_unprot)
      cmd_page_reg <= page_addr;
  end

  // Copy request is a level held until the array reports completion.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      copy_req_reg <= 1'b0;
    else if (ce)
    begin
      if (state_reg == ST_DECIDE && !page_hit && !copy_blocked)
        copy_req_reg <= 1'b1;
      else if (state_reg == ST_COPY && arr_copy_done)
        copy_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      buf_page_reg  <= '0;
      buf_valid_reg <= 1'b0;
    end
    else if (ce && state_reg == ST_COPY && arr_copy_done)
    begin
      // Even an uncorrectable copy leaves its data in the buffer.
      buf_page_reg  <= cmd_page_reg;
      buf_valid_reg <= 1'b1;
    end
  end

  // Fabric writes into the buffer win over a discard in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      modified_reg <= 1'b0;
    else if (ce)
    begin
      if (buf_write)
        modified_reg <= 1'b1;
      else if (start_discard)
        modified_reg <= 1'b0;
      else if (state_reg == ST_COPY && arr_copy_done)
        modified_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      status_reg <= STAT_OK;
    else if (ce)
    begin
      if (start_discard)
        status_reg <= STAT_OK;
      else if (state_reg == ST_DECIDE && !page_hit && conflict)
        status_reg <= STAT_CONFLICT;
      else if (state_reg == ST_DECIDE && (page_hit || copy_blocked))
        status_reg <= STAT_OK;
      else if (state_reg == ST_COPY && arr_copy_done)
      begin
        if (arr_ecc_double)
          status_reg <= STAT_UNCORR;
        else if (arr_ecc_single)
          status_reg <= STAT_CORR;
        else
          status_reg <= STAT_OK;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      done_reg <= 1'b0;
    else if (ce)
      done_reg <= state_reg == ST_FINISH;
  end

  assign busy          = state_reg != ST_IDLE;
  assign status        = status_reg;
  assign cmd_done      = done_reg;
  assign arr_copy_req  = copy_req_reg;
  assign arr_copy_page = cmd_page_reg;

  // ==========================================================
  // Interrupts: sticky events, set wins over clear
  always_comb
  begin
    irq_ev             = 4'h0;
    irq_ev[IRQ_DONE]   = ce && state_reg == ST_FINISH;
    irq_ev[IRQ_SINGLE] = ce && state_reg == ST_COPY && arr_copy_done && arr_ecc_single && !arr_ecc_double;
    irq_ev[IRQ_DOUBLE] = ce && state_reg == ST_COPY && arr_copy_done && arr_ecc_double;
    irq_ev[IRQ_CONFL]  = ce && state_reg == ST_DECIDE && !page_hit && conflict;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq_stat_reg <= 4'h0;
    else if (wr_take && hit(avs_address, ADR_IRQ_CLR))
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata[3:0]) | irq_ev;
    else
      irq_stat_reg <= irq_stat_reg | irq_ev;
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  prot_cleared_a: assert property (start_unprot |=> !prot_mem[$past(page_addr)])
    else $error("Unprotected page still protected");

  miss_copies_a: assert property (ce && state_reg == ST_DECIDE && !page_hit && !copy_blocked
    |=> arr_copy_req && arr_copy_page == $past(cmd_page_reg))
    else $error("Missed page not copied");

  guard_no_copy_a: assert property (ce && state_reg == ST_DECIDE && copy_blocked && !page_hit
    |=> !arr_copy_req ##1 $stable(buf_page_reg))
    else $error("Guarded buffer was overwritten");

  single_status_a: assert property (ce && state_reg == ST_COPY && arr_copy_done
    && arr_ecc_single && !arr_ecc_double |=> status == 2'h1)
    else $error("Corrected error not reported");

  conflict_status_a: assert property (ce && state_reg == ST_DECIDE && !page_hit && conflict
    |=> status == 2'h3 && $stable(buf_page_reg) && !arr_copy_req)
    else $error("Conflict not reported");

  double_status_a: assert property (ce && state_reg == ST_COPY && arr_copy_done && arr_ecc_double
    |=> status == 2'h2 && buf_valid_reg && buf_page_reg == $past(cmd_page_reg))
    else $error("Uncorrectable copy mishandled");

  discard_clears_a: assert property (start_discard && !buf_write |=> !modified_reg && busy)
    else $error("Discard did not clear modified");

  busy_span_a: assert property (start_unprot |=> busy [*2])
    else $error("Busy dropped early");

  clean_status_a: assert property (ce && state_reg == ST_DECIDE && page_hit |=> status == 2'h0)
    else $error("Clean completion not status 00");

  cover_copy_c: cover property (ce && state_reg == ST_COPY && arr_copy_done);
  cover_conflict_c: cover property (irq_ev[IRQ_CONFL]);
  cover_discard_c: cover property (start_discard ##1 busy ##1 !busy);

endmodule

// >>> dv/fpb_array_model.sv
`timescale 1ns/1ps
// ==========================================================
// Flash array stand-in
// It answers a copy request after a delay chosen by the bench.
module fpb_array_model
#(
  parameter int LAT_W = 4
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Copy port
  input  wire logic             req,
  output logic                  done,
  output logic                  ecc_single,
  output logic                  ecc_double,
  // Behaviour set by the bench
  input  wire logic [LAT_W-1:0] lat,
  input  wire logic [1:0]       err
);
  logic [LAT_W-1:0] cnt_reg;
  logic             junk_reg;

  // The error flags mean nothing outside done, so they wander there.
  assign ecc_single = done ? err[0] : junk_reg;
  assign ecc_double = done ? err[1] : ~junk_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_reg  <= '0;
      done     <= 1'b0;
      junk_reg <= 1'b0;
    end
    else
    begin
      junk_reg <= ~junk_reg;
      done     <= req && !done && cnt_reg == lat;
      cnt_reg  <= (req && !done) ? cnt_reg + 1'b1 : '0;
    end
  end
endmodule

// >>> dv/tb_flash_page_buffer_ops.sv
`timescale 1ns/1ps
module tb_flash_page_buffer_ops
  import fpb_pkg::*;
;
  logic        clk, nrst, ce, avs_read, avs_write, avs_waitrequest, busy, cmd_done, irq;
  logic        unprotect_request, discard_request, buffer_keep_guard, buf_write;
  logic        arr_copy_req, arr_copy_done, arr_ecc_single, arr_ecc_double;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, page_addr, arr_copy_page, lat, last_pg;
  logic [1:0]  status, err;
  int          copies, fails, checks_done;

  fpb_page_ops #(.PAGE_W(4)) fpb_page_ops_inst (
    .clk(clk), .nrst(nrst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .unprotect_request(unprotect_request), .discard_request(discard_request),
    .page_addr(page_addr), .buffer_keep_guard(buffer_keep_guard), .buf_write(buf_write), .busy(busy),
    .status(status), .cmd_done(cmd_done), .arr_copy_req(arr_copy_req), .arr_copy_page(arr_copy_page),
    .arr_copy_done(arr_copy_done), .arr_ecc_single(arr_ecc_single), .arr_ecc_double(arr_ecc_double), .irq(irq));

  fpb_array_model fpb_array_model_inst (
    .clk(clk), .nrst(nrst), .req(arr_copy_req), .done(arr_copy_done), .ecc_single(arr_ecc_single),
    .ecc_double(arr_ecc_double), .lat(lat), .err(err));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (arr_copy_done === 1'b1)
    begin
      copies  <= copies + 1;
      last_pg <= arr_copy_page;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // The request stands until waitrequest is sampled low at a rising edge; read data is taken there.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20)
    begin
      fails++;
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x & m);
  endtask

  // One strobe cycle is enough; busy is counted until it falls.
  task automatic cmd(input logic unp, input logic [3:0] pg, input logic [1:0] est, input int enb, input int ecp);
    int i;
    int nb;
    int c0;
    c0 = copies;
    nb = 0;
    @(posedge clk);
    unprotect_request <= unp;
    discard_request   <= !unp;
    page_addr         <= pg;
    @(posedge clk);
    unprotect_request <= 1'b0;
    discard_request   <= 1'b0;
    for (i = 0; i < 50; i++)
    begin
      @(negedge clk);
      if (busy !== 1'b1)
        break;
      nb++;
    end
    if (i == 50)
    begin
      fails++;
      summarize();
    end
    chk("cmd_done", 1'b1, cmd_done);
    chk("busy_cycles", enb, nb);
    chk("status", est, status);
    chk("copies", ecp, copies - c0);
    if (ecp > 0)
      chk("copy_page", pg, last_pg);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("busy", 1'b0, busy);
    chk("status", STAT_OK, status);
    chk("irq", 1'b0, irq);
    rdc("ctrl", ADR_CTRL, 32'h1, 32'h1);
    rdc("irq_en", ADR_IRQ_EN, 32'hF, 32'h0);
    rdc("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_clean();
    wr(ADR_PROT_SEL, 32'h5);
    wr(ADR_PROT_DATA, 32'h1);
    rdc("prot_set", ADR_PROT_DATA, 32'h1, 32'h1);
    lat <= 4'h2;
    cmd(1'b1, 4'h5, STAT_OK, 6, 1);
    rdc("prot_clr", ADR_PROT_DATA, 32'h1, 32'h0);
    cmd(1'b1, 4'h5, STAT_OK, 2, 0);
  endtask

  task automatic t_errors();
    wr(ADR_IRQ_EN, 32'h2);
    lat <= 4'h0;
    err <= 2'h1;
    cmd(1'b1, 4'h6, STAT_CORR, 4, 1);
    chk("irq_on", 1'b1, irq);
    wr(ADR_IRQ_EN, 32'h0);
    @(negedge clk);
    chk("irq_masked", 1'b0, irq);
    wr(ADR_IRQ_EN, 32'h2);
    wr(ADR_IRQ_CLR, 32'hF);
    @(negedge clk);
    chk("irq_cleared", 1'b0, irq);
    rdc("irq_stat", ADR_IRQ_STAT, 32'hF, 32'h0);
    err <= 2'h2;
    cmd(1'b1, 4'h7, STAT_UNCORR, 4, 1);
    rdc("bad_page_kept", ADR_STATE, 32'hF13, 32'h712);
  endtask

  task automatic t_guard();
    @(posedge clk);
    buf_write <= 1'b1;
    @(posedge clk);
    buf_write         <= 1'b0;
    buffer_keep_guard <= 1'b1;
    err               <= 2'h0;
    rdc("modified", ADR_STATE, 32'h8, 32'h8);
    cmd(1'b1, 4'h8, STAT_CONFLICT, 2, 0);
    rdc("page_not_loaded", ADR_STATE, 32'hF1B, 32'h71B);
    cmd(1'b0, 4'h0, STAT_OK, 1, 0);
    rdc("unmodified", ADR_STATE, 32'h8, 32'h0);
    cmd(1'b1, 4'h9, STAT_OK, 2, 0);
    @(posedge clk);
    buffer_keep_guard <= 1'b0;
    cmd(1'b1, 4'h9, STAT_OK, 4, 1);
  endtask

  // Strobes while commands are disabled or ce is low must start nothing.
  task automatic t_refused();
    wr(ADR_CTRL, 32'h0);
    @(posedge clk);
    unprotect_request <= 1'b1;
    page_addr         <= 4'h3;
    @(posedge clk);
    unprotect_request <= 1'b0;
    @(negedge clk);
    chk("busy_disabled", 1'b0, busy);
    wr(ADR_CTRL, 32'h1);
    avs_byteenable <= 4'h0;
    wr(ADR_IRQ_EN, 32'hF);
    avs_byteenable <= 4'hF;
    rdc("irq_en_kept", ADR_IRQ_EN, 32'hF, 32'h2);
    @(posedge clk);
    ce                <= 1'b0;
    unprotect_request <= 1'b1;
    @(posedge clk);
    ce                <= 1'b1;
    unprotect_request <= 1'b0;
    @(negedge clk);
    chk("busy_frozen", 1'b0, busy);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {nrst, avs_read, avs_write, unprotect_request, discard_request, buffer_keep_guard, buf_write} = '0;
    {avs_address, avs_writedata, page_addr, lat, err} = '0;
    avs_byteenable = 4'hF;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    t_reset();
    t_clean();
    t_errors();
    t_guard();
    t_refused();
    summarize();
  end
endmodule
